// [status_protect_cfg.svh]
`ifndef STATUS_PROTECT_CFG_SVH
`define STATUS_PROTECT_CFG_SVH

// Instruction codes seen at the end of a frame
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_WRITE 8'h02
`define OP_ARRAY_READ 8'h03
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ 8'h05
`define OP_WRITE_ENABLE 8'h06
`define OP_STATUS2_WRITE 8'h31
`define OP_DEEP_SLEEP 8'h79

// Status byte one fields
`define S1_LOCK_BIT 7
`define S1_SLEEP_BIT 4
`define S1_BP_HIGH_BIT 3
`define S1_BP_LOW_BIT 2
`define S1_LATCH_BIT 1
`define S1_BUSY_BIT 0

// Status byte two fields
`define S2_SLOW_BIT 1
`define S2_AUTO_BIT 0

// Serial clock counts that make a frame complete
`define BITS_SHORT 12'h008
`define BITS_STATUS_WRITE 12'h010
`define BITS_ARRAY_HEADER 12'h018
`define PAGE_BYTES 64

// Self-timed write durations
`define CLOCK_PERIOD_NS 20
`define ARRAY_WRITE_TIME_NS 100000
`define STATUS1_WRITE_TIME_NS 100000
`define STATUS2_WRITE_TIME_NS 1000
`define ARRAY_WRITE_CYCLES (`ARRAY_WRITE_TIME_NS / `CLOCK_PERIOD_NS)
`define STATUS1_WRITE_CYCLES (`STATUS1_WRITE_TIME_NS / `CLOCK_PERIOD_NS)
`define STATUS2_WRITE_CYCLES (`STATUS2_WRITE_TIME_NS / `CLOCK_PERIOD_NS)

// Oscillator slowdown duty pattern
`define SLOW_PERIOD 16
`define SLOW_ACTIVE 4

// Non-volatile cell contents at power-up
`define RESET_LOCK 1'b0
`define RESET_BP 2'h0
`define RESET_SLOW 1'b0
`define RESET_AUTO 1'b0

`endif

// [status_protect_pkg.sv]
package status_protect_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WRITING = 2'b01,
      ST_SLEEP = 2'b10
   } mode_e;

   typedef enum logic [1:0] {
      JOB_NONE = 2'b00,
      JOB_STATUS1 = 2'b01,
      JOB_STATUS2 = 2'b10,
      JOB_ARRAY = 2'b11
   } job_e;

   typedef logic [23:0] count_t;

   typedef struct packed {
      mode_e mode;
      job_e job;
      logic lock;
      logic [1:0] bp;
      logic write_latch;
      logic slow_sel;
      logic auto_sel;
      logic [7:0] status_one;
      logic [7:0] status_two;
      logic array_go;
      logic [14:0] array_addr;
      logic ignored;
   } ctrl_s;

   typedef struct packed {
      logic running;
      count_t count;
      logic done;
   } timer_s;

   typedef struct packed {
      logic [15:0] phase;
      logic tick;
   } duty_s;

endpackage

// [write_timer.sv]
`timescale 1ns/10ps
`include "status_protect_cfg.svh"

module write_timer (
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire status_protect_pkg::count_t load,
   input wire logic tick,
   output logic running,
   output logic done
);
   status_protect_pkg::timer_s cur_reg;
   status_protect_pkg::timer_s cur_next;

   always_comb begin
      cur_next = cur_reg;
      cur_next.done = 1'b0;
      if (start) begin
         cur_next.running = 1'b1;
         cur_next.count = (load == '0) ? 24'h000001 : load;
      end else if (cur_reg.running && tick) begin
         if (cur_reg.count == 24'h000001) begin
            cur_next.running = 1'b0;
            cur_next.done = 1'b1;
         end else begin
            cur_next.count = cur_reg.count - 24'h000001;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   assign running = cur_reg.running;
   assign done = cur_reg.done;

   a_done_ends_run: assert property (@(posedge clock) disable iff (rst)
      done |-> !running && $past(running))
      else $error("timer done without a run ending");
endmodule

// [duty_divider.sv]
`timescale 1ns/10ps
`include "status_protect_cfg.svh"

module duty_divider #(
   parameter int PERIOD = `SLOW_PERIOD,
   parameter int ACTIVE = `SLOW_ACTIVE
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic slow,
   output logic tick
);
   status_protect_pkg::duty_s cur_reg;
   status_protect_pkg::duty_s cur_next;

   // Full speed ticks every cycle; slow mode bursts then idles
   always_comb begin
      cur_next = cur_reg;
      if (cur_reg.phase == 16'(PERIOD - 1)) begin
         cur_next.phase = 16'h0000;
      end else begin
         cur_next.phase = cur_reg.phase + 16'h0001;
      end
      cur_next.tick = !slow || (cur_next.phase < 16'(ACTIVE));
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   assign tick = cur_reg.tick;
endmodule

// [serial_memory_status_protect.sv]
`timescale 1ns/10ps
`include "status_protect_cfg.svh"
// Contract
// - Status register is two bytes; byte one holds busy, latch, config.
// - Both status bytes are readable every cycle, even while writing.
// - Byte one: lock, 0, 0, sleep, protect high, protect low, latch, busy.
// - Busy reads 1 during a self-timed write, else 0.
// - Write latch reads 1 when writing is enabled, 0 otherwise.
// - Sleep flag is read-only and volatile, pollable for readiness.
// - Sleep flag reads 1 in deep sleep, 0 in standby or active.
// - Reserved bits of both bytes always read zero.
// - Lock bit is non-volatile; once 1, byte one refuses writes.
// - Two non-volatile block-protect bits select the shielded array region.
// - A status write changes only protect bits and lock bit.
// - Protect codes: none, 6000-7FFF, 4000-7FFF, whole 0-7FFF.
// - Byte two holds only slowdown select bit 1, auto sleep bit 0.
// - Auto sleep bit picks standby or deep sleep after an array or byte-one write.
// - Slowdown bit makes the write timer run on a duty pattern.
// - Write frames with a wrong clock count are ignored.
// - Program and status writes are ignored while the latch is clear.
// - Latch clears at power-up, on write disable and when a self-timed write finishes.
// - Byte-two write sets busy; finishing clears busy and latch.
module serial_memory_status_protect #(
   parameter int ARRAY_WRITE_CYCLES = `ARRAY_WRITE_CYCLES,
   parameter int STATUS1_WRITE_CYCLES = `STATUS1_WRITE_CYCLES,
   parameter int PAGE_BYTES = `PAGE_BYTES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [11:0] cmd_bits,
   input wire logic [7:0] cmd_data,
   input wire logic [14:0] cmd_addr,
   input wire logic exit_sleep,
   output logic [7:0] status_byte_one,
   output logic [7:0] status_byte_two,
   output logic array_write_start,
   output logic [14:0] array_write_addr,
   output logic cmd_ignored,
   output logic osc_slow_active
);
   localparam int STATUS2_WRITE_CYCLES = `STATUS2_WRITE_CYCLES;
   localparam logic [11:0] ARRAY_BITS_MIN = 12'(`BITS_ARRAY_HEADER + 8);
   localparam logic [11:0] ARRAY_BITS_MAX =
      12'(`BITS_ARRAY_HEADER + 8 * PAGE_BYTES);

   status_protect_pkg::ctrl_s cur_reg;
   status_protect_pkg::ctrl_s cur_next;

   logic timer_start;
   status_protect_pkg::count_t timer_load;
   logic timer_running;
   logic timer_done;
   logic duty_tick;
   logic slowing;

   // Page writes never cross an 8K boundary, so the start address decides
   function automatic logic in_protected(input logic [1:0] bp,
                                         input logic [14:0] addr);
      logic hit;
      hit = 1'b0;
      unique case (bp)
         2'b00: hit = 1'b0;
         2'b01: hit = (addr[14:13] == 2'b11);
         2'b10: hit = addr[14];
         2'b11: hit = 1'b1;
      endcase
      return hit;
   endfunction

   logic is_read;
   logic bits_short_ok;
   logic bits_status_ok;
   logic bits_array_ok;
   logic target_protected;

   assign is_read = (cmd_code == `OP_STATUS_READ) ||
                    (cmd_code == `OP_ARRAY_READ);
   assign bits_short_ok = (cmd_bits == `BITS_SHORT);
   assign bits_status_ok = (cmd_bits == `BITS_STATUS_WRITE);
   assign bits_array_ok = (cmd_bits >= ARRAY_BITS_MIN) &&
                          (cmd_bits <= ARRAY_BITS_MAX) &&
                          (cmd_bits[2:0] == 3'h0);
   assign target_protected = in_protected(cur_reg.bp, cmd_addr);

   always_comb begin
      cur_next = cur_reg;
      cur_next.array_go = 1'b0;
      cur_next.ignored = 1'b0;
      timer_start = 1'b0;
      timer_load = 24'(ARRAY_WRITE_CYCLES);
      unique case (cur_reg.mode)
         status_protect_pkg::ST_IDLE: begin
            if (cmd_valid && !is_read) begin
               cur_next.ignored = 1'b1;
               unique case (cmd_code)
                  `OP_WRITE_ENABLE: begin
                     if (bits_short_ok) begin
                        cur_next.write_latch = 1'b1;
                        cur_next.ignored = 1'b0;
                     end
                  end
                  `OP_WRITE_DISABLE: begin
                     if (bits_short_ok) begin
                        cur_next.write_latch = 1'b0;
                        cur_next.ignored = 1'b0;
                     end
                  end
                  `OP_STATUS_WRITE: begin
                     // Locked byte one refuses, latch kept
                     if (bits_status_ok && cur_reg.write_latch && !cur_reg.lock) begin
                        // Only lock and protect bits change
                        cur_next.lock = cmd_data[`S1_LOCK_BIT];
                        cur_next.bp = {cmd_data[`S1_BP_HIGH_BIT],
                                       cmd_data[`S1_BP_LOW_BIT]};
                        cur_next.mode = status_protect_pkg::ST_WRITING;
                        cur_next.job = status_protect_pkg::JOB_STATUS1;
                        timer_start = 1'b1;
                        timer_load = 24'(STATUS1_WRITE_CYCLES);
                        cur_next.ignored = 1'b0;
                     end
                  end
                  `OP_STATUS2_WRITE: begin
                     if (bits_status_ok && cur_reg.write_latch) begin
                        cur_next.slow_sel = cmd_data[`S2_SLOW_BIT];
                        cur_next.auto_sel = cmd_data[`S2_AUTO_BIT];
                        cur_next.mode = status_protect_pkg::ST_WRITING;
                        cur_next.job = status_protect_pkg::JOB_STATUS2;
                        timer_start = 1'b1;
                        timer_load = 24'(STATUS2_WRITE_CYCLES);
                        cur_next.ignored = 1'b0;
                     end
                  end
                  `OP_ARRAY_WRITE: begin
                     // Protected target: no array cycle at all
                     if (bits_array_ok && cur_reg.write_latch && !target_protected) begin
                        cur_next.array_go = 1'b1;
                        cur_next.array_addr = cmd_addr;
                        cur_next.mode = status_protect_pkg::ST_WRITING;
                        cur_next.job = status_protect_pkg::JOB_ARRAY;
                        timer_start = 1'b1;
                        timer_load = 24'(ARRAY_WRITE_CYCLES);
                        cur_next.ignored = 1'b0;
                     end
                  end
                  `OP_DEEP_SLEEP: begin
                     if (bits_short_ok) begin
                        cur_next.mode = status_protect_pkg::ST_SLEEP;
                        cur_next.ignored = 1'b0;
                     end
                  end
                  default: begin
                     cur_next.ignored = 1'b0;
                  end
               endcase
            end
         end
         status_protect_pkg::ST_WRITING: begin
            // Only status and array reads are served while the cell write runs
            cur_next.ignored = cmd_valid && !is_read;
            if (timer_done) begin
               cur_next.write_latch = 1'b0;
               cur_next.job = status_protect_pkg::JOB_NONE;
               // Byte-two write never ends in deep sleep
               if (cur_reg.auto_sel &&
                   cur_reg.job != status_protect_pkg::JOB_STATUS2) begin
                  cur_next.mode = status_protect_pkg::ST_SLEEP;
               end else begin
                  cur_next.mode = status_protect_pkg::ST_IDLE;
               end
            end
         end
         status_protect_pkg::ST_SLEEP: begin
            cur_next.ignored = cmd_valid && !is_read;
            if (exit_sleep) begin
               cur_next.mode = status_protect_pkg::ST_IDLE;
            end
         end
         default: begin
            cur_next.mode = status_protect_pkg::ST_IDLE;
         end
      endcase
      // Image built from next state so reads never lag
      cur_next.status_one = 8'h00;
      cur_next.status_one[`S1_LOCK_BIT] = cur_next.lock;
      cur_next.status_one[`S1_SLEEP_BIT] =
         (cur_next.mode == status_protect_pkg::ST_SLEEP);
      cur_next.status_one[`S1_BP_HIGH_BIT] = cur_next.bp[1];
      cur_next.status_one[`S1_BP_LOW_BIT] = cur_next.bp[0];
      cur_next.status_one[`S1_LATCH_BIT] = cur_next.write_latch;
      cur_next.status_one[`S1_BUSY_BIT] =
         (cur_next.mode == status_protect_pkg::ST_WRITING);
      cur_next.status_two = 8'h00;
      cur_next.status_two[`S2_SLOW_BIT] = cur_next.slow_sel;
      cur_next.status_two[`S2_AUTO_BIT] = cur_next.auto_sel;
   end

   // Non-volatile cells are loaded with the fixed RESET_LOCK, RESET_BP, RESET_SLOW and RESET_AUTO values
   always_ff @(posedge clock) begin
      if (rst) begin
         cur_reg.mode <= status_protect_pkg::ST_IDLE;
         cur_reg.job <= status_protect_pkg::JOB_NONE;
         cur_reg.lock <= `RESET_LOCK;
         cur_reg.bp <= `RESET_BP;
         cur_reg.write_latch <= 1'b0;
         cur_reg.slow_sel <= `RESET_SLOW;
         cur_reg.auto_sel <= `RESET_AUTO;
         cur_reg.status_one <= {`RESET_LOCK, 3'h0, `RESET_BP, 2'h0};
         cur_reg.status_two <= {6'h00, `RESET_SLOW, `RESET_AUTO};
         cur_reg.array_go <= 1'b0;
         cur_reg.array_addr <= 15'h0000;
         cur_reg.ignored <= 1'b0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   assign slowing = cur_reg.slow_sel && timer_running;

   duty_divider #(
      .PERIOD(`SLOW_PERIOD),
      .ACTIVE(`SLOW_ACTIVE)
   ) u_duty (
      .clock(clock),
      .rst(rst),
      .slow(slowing),
      .tick(duty_tick)
   );

   write_timer u_timer (
      .clock(clock),
      .rst(rst),
      .start(timer_start),
      .load(timer_load),
      .tick(duty_tick),
      .running(timer_running),
      .done(timer_done)
   );

   assign status_byte_one = cur_reg.status_one;
   assign status_byte_two = cur_reg.status_two;
   assign array_write_start = cur_reg.array_go;
   assign array_write_addr = cur_reg.array_addr;
   assign cmd_ignored = cur_reg.ignored;
   assign osc_slow_active = slowing;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   logic idle_now;
   assign idle_now = (cur_reg.mode == status_protect_pkg::ST_IDLE);

   a_reserved_read_zero: assert property (
      status_byte_one[6:5] == 2'h0 && status_byte_two[7:2] == 6'h00)
      else $error("reserved status bit set");

   a_enable_sets_latch: assert property (
      idle_now && cmd_valid && cmd_code == `OP_WRITE_ENABLE &&
      cmd_bits == `BITS_SHORT |=> status_byte_one[`S1_LATCH_BIT])
      else $error("write enable did not set latch");

   a_lock_holds_byte: assert property (
      cur_reg.lock && cmd_valid && cmd_code == `OP_STATUS_WRITE
      |=> $stable({status_byte_one[7], status_byte_one[3:2]}) && cmd_ignored)
      else $error("locked byte one changed");

   a_latch_guards_write: assert property (
      idle_now && cmd_valid && !cur_reg.write_latch && !is_read &&
      cmd_code != `OP_WRITE_ENABLE && cmd_code != `OP_WRITE_DISABLE &&
      cmd_code != `OP_DEEP_SLEEP |=> !status_byte_one[`S1_BUSY_BIT])
      else $error("write accepted with latch clear");

   a_short_frame_drop: assert property (
      idle_now && cmd_valid && cmd_code == `OP_STATUS2_WRITE &&
      cmd_bits != `BITS_STATUS_WRITE |=> cmd_ignored && $stable(status_byte_two))
      else $error("short status frame accepted");

   a_protect_blocks: assert property (
      cmd_valid && cmd_code == `OP_ARRAY_WRITE && target_protected
      |=> !array_write_start)
      else $error("array write into protected region");

   a_status2_sets_busy: assert property (
      idle_now && cmd_valid && cmd_code == `OP_STATUS2_WRITE &&
      cmd_bits == `BITS_STATUS_WRITE && cur_reg.write_latch
      |=> status_byte_one[`S1_BUSY_BIT] ##1 status_byte_one[`S1_LATCH_BIT])
      else $error("status byte two write did not start");

   a_finish_clears: assert property (
      timer_done |=> !status_byte_one[`S1_BUSY_BIT] &&
      !status_byte_one[`S1_LATCH_BIT])
      else $error("busy or latch left set after write");

   a_auto_sleep_entry: assert property (
      timer_done && cur_reg.job == status_protect_pkg::JOB_ARRAY &&
      cur_reg.auto_sel |=> status_byte_one[`S1_SLEEP_BIT])
      else $error("no deep sleep after write");

   a_slow_stretches: assert property (
      slowing && !duty_tick |=> !timer_done)
      else $error("timer advanced on an idle slow cycle");

   a_status1_latch_gate: assert property (
      idle_now && cmd_valid && cmd_code == `OP_STATUS_WRITE && !cur_reg.write_latch
      |=> cmd_ignored && $stable(status_byte_one[7:2]))
      else $error("byte one written with latch clear");

   a_busy_refuses_cmd: assert property (
      status_byte_one[`S1_BUSY_BIT] && cmd_valid && !is_read
      |=> cmd_ignored)
      else $error("command taken while busy");

   a_sleep_refuses_cmd: assert property (
      status_byte_one[`S1_SLEEP_BIT] && cmd_valid && !is_read && !exit_sleep
      |=> cmd_ignored && status_byte_one[`S1_SLEEP_BIT])
      else $error("command taken in deep sleep");

   a_wake_leaves_sleep: assert property (
      status_byte_one[`S1_SLEEP_BIT] && exit_sleep
      |=> !status_byte_one[`S1_SLEEP_BIT] && !status_byte_one[`S1_BUSY_BIT])
      else $error("wake did not reach standby");

   a_status2_no_sleep: assert property (
      timer_done && cur_reg.job == status_protect_pkg::JOB_STATUS2
      |=> !status_byte_one[`S1_SLEEP_BIT])
      else $error("byte two write ended in deep sleep");

   a_array_start_busy: assert property (
      array_write_start |-> status_byte_one[`S1_BUSY_BIT] && timer_running)
      else $error("array write started without busy");

   a_read_no_effect: assert property (
      cmd_valid && is_read |=> !cmd_ignored && $stable(status_byte_two))
      else $error("status read disturbed the block");

   c_wake: cover property (status_byte_one[`S1_SLEEP_BIT] && exit_sleep);
   c_status_write: cover property (
      cur_reg.job == status_protect_pkg::JOB_STATUS1 && timer_done);
   c_array_to_sleep: cover property (
      array_write_start ##[1:200] status_byte_one[`S1_SLEEP_BIT]);
   c_slow_write: cover property (slowing ##1 timer_done);
endmodule

// [spi_master_model.sv]
`timescale 1ns/10ps

module spi_master_model (
   input wire logic clock,
   input wire logic req,
   input wire logic [7:0] req_code,
   input wire logic [11:0] req_bits,
   input wire logic [7:0] req_data,
   input wire logic [14:0] req_addr,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [11:0] cmd_bits,
   output logic [7:0] cmd_data,
   output logic [14:0] cmd_addr
);
   logic [7:0] last_code;
   logic [11:0] last_bits;
   logic [7:0] last_data;
   logic [14:0] last_addr;

   always_ff @(posedge clock) begin
      if (req) begin
         last_code <= req_code;
         last_bits <= req_bits;
         last_data <= req_data;
         last_addr <= req_addr;
      end
   end

   // Frame ends exactly when asked; the bench alone decides on counts
   // and on a preceding enable frame
   assign cmd_valid = req;
   // Outside a frame the fields carry nothing, so show the inverse
   assign cmd_code = req ? req_code : ~last_code;
   assign cmd_bits = req ? req_bits : ~last_bits;
   assign cmd_data = req ? req_data : ~last_data;
   assign cmd_addr = req ? req_addr : ~last_addr;
endmodule

// [serial_memory_status_protect_test.sv]
`timescale 1ns/10ps
`include "status_protect_cfg.svh"

module serial_memory_status_protect_test;
   logic clock;
   logic rst;
   logic req;
   logic [7:0] r_code;
   logic [11:0] r_bits;
   logic [7:0] r_data;
   logic [14:0] r_addr;
   logic exit_sleep;
   logic cmd_valid;
   logic [7:0] cmd_code;
   logic [11:0] cmd_bits;
   logic [7:0] cmd_data;
   logic [14:0] cmd_addr;
   logic [7:0] s1;
   logic [7:0] s2;
   logic aws;
   logic [14:0] awa;
   logic ign;
   logic osa;
   int bad_count;
   int checks;
   logic [14:0] lo;
   logic [14:0] hi;

   spi_master_model master (.clock(clock), .req(req), .req_code(r_code),
      .req_bits(r_bits), .req_data(r_data), .req_addr(r_addr),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bits(cmd_bits),
      .cmd_data(cmd_data), .cmd_addr(cmd_addr));

   serial_memory_status_protect #(.ARRAY_WRITE_CYCLES(20),
      .STATUS1_WRITE_CYCLES(20), .PAGE_BYTES(64)) dut (.clock(clock),
      .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_bits(cmd_bits), .cmd_data(cmd_data), .cmd_addr(cmd_addr),
      .exit_sleep(exit_sleep), .status_byte_one(s1), .status_byte_two(s2),
      .array_write_start(aws), .array_write_addr(awa), .cmd_ignored(ign),
      .osc_slow_active(osa));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic conclude();
      if (bad_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_addr(input logic [14:0] got, input logic [14:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One frame; outputs are looked at just after the edge that took it
   task automatic send(input logic [7:0] code, input logic [11:0] bits,
         input logic [7:0] data, input logic [14:0] addr);
      @(posedge clock);
      req <= 1'b1;
      r_code <= code;
      r_bits <= bits;
      r_data <= data;
      r_addr <= addr;
      @(posedge clock);
      req <= 1'b0;
      #1;
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (s1[0] !== 1'b0 && n < 2000) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk_bit(s1[0], 1'b0);
   endtask

   task automatic write_enable_cmd();
      send(`OP_WRITE_ENABLE, 12'h008, 8'h00, 15'h0000);
   endtask

   // Wake pulse, outputs looked at just after the edge that took it
   task automatic wake();
      @(posedge clock);
      exit_sleep <= 1'b1;
      @(posedge clock);
      exit_sleep <= 1'b0;
      #1;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      conclude();
   end

   initial begin
      rst = 1'b1;
      req = 1'b0;
      r_code = 8'h00;
      r_bits = 12'h000;
      r_data = 8'h00;
      r_addr = 15'h0000;
      exit_sleep = 1'b0;
      bad_count = 0;
      checks = 0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      #1;
      chk_byte(s1, 8'h00);
      chk_byte(s2, 8'h00);
      send(`OP_STATUS_WRITE, 12'h010, 8'h0C, 15'h0000);
      chk_bit(ign, 1'b1);
      chk_byte(s1, 8'h00);
      send(`OP_WRITE_ENABLE, 12'h007, 8'h00, 15'h0000);
      chk_bit(ign, 1'b1);
      write_enable_cmd();
      chk_byte(s1, 8'h02);
      send(`OP_STATUS_READ, 12'h010, 8'h00, 15'h0000);
      chk_bit(ign, 1'b0);
      chk_byte(s1, 8'h02);
      // Last free and first shielded start address for each code
      for (int b = 3; b >= 0; b--) begin
         write_enable_cmd();
         send(`OP_STATUS_WRITE, 12'h010, 8'h73 | 8'(b << 2), 15'h0000);
         chk_byte(s1, 8'(b << 2) | 8'h03);
         wait_done();
         chk_byte(s1, 8'(b << 2));
         lo = (b == 0) ? 15'h7FFF : (b == 1) ? 15'h5FFF : 15'h3FFF;
         hi = (b == 1) ? 15'h6000 : (b == 2) ? 15'h4000 : 15'h0000;
         write_enable_cmd();
         if (b != 0) begin
            send(`OP_ARRAY_WRITE, 12'h020, 8'h00, hi);
            chk_bit(ign, 1'b1);
            chk_bit(aws, 1'b0);
            chk_bit(s1[1], 1'b1);
         end
         if (b != 3) begin
            send(`OP_ARRAY_WRITE, 12'h020, 8'h00, lo);
            chk_bit(aws, 1'b1);
            chk_addr(awa, lo);
            write_enable_cmd();
            chk_bit(ign, 1'b1);
            wait_done();
            chk_byte(s1, 8'(b << 2));
         end
      end
      write_enable_cmd();
      send(`OP_STATUS2_WRITE, 12'h00F, 8'hFF, 15'h0000);
      chk_bit(ign, 1'b1);
      chk_byte(s2, 8'h00);
      send(`OP_STATUS2_WRITE, 12'h010, 8'hFF, 15'h0000);
      chk_byte(s2, 8'h03);
      chk_byte(s1, 8'h03);
      chk_bit(osa, 1'b1);
      wait_done();
      chk_byte(s1, 8'h00);
      chk_bit(osa, 1'b0);
      write_enable_cmd();
      send(`OP_ARRAY_WRITE, 12'h020, 8'h00, 15'h0100);
      chk_bit(aws, 1'b1);
      wait_done();
      chk_byte(s1, 8'h10);
      write_enable_cmd();
      chk_bit(ign, 1'b1);
      chk_byte(s1, 8'h10);
      wake();
      chk_byte(s1, 8'h00);
      write_enable_cmd();
      send(`OP_WRITE_DISABLE, 12'h008, 8'h00, 15'h0000);
      chk_byte(s1, 8'h00);
      write_enable_cmd();
      send(`OP_STATUS_WRITE, 12'h010, 8'h84, 15'h0000);
      chk_byte(s1, 8'h87);
      wait_done();
      chk_byte(s1, 8'h94);
      wake();
      chk_byte(s1, 8'h84);
      write_enable_cmd();
      send(`OP_STATUS_WRITE, 12'h010, 8'h00, 15'h0000);
      chk_bit(ign, 1'b1);
      chk_byte(s1, 8'h86);
      conclude();
   end
endmodule
